// File: pkg/cbe_pkg.sv
// Purpose: shared constants and types of the bit-op and transfer execution core
// Assumes: one synchronous clock domain, decoded instructions arrive from a decoder
// Notes:   flag positions follow the status register layout
package cbe_pkg;

  // status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // reset values
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [15:0] SP_RESET     = 16'h00ff;

  // register file layout
  localparam logic [4:0] PTR_X_LO     = 5'h1a;
  localparam logic [4:0] PTR_Z_LO     = 5'h1e;
  localparam logic [4:0] REG_ZERO_IDX = 5'h00;
  localparam logic [4:0] REG_ONE_IDX  = 5'h01;

  // decoded operations
  typedef enum logic [4:0] {
    OP_NOP, OP_ROT_RC, OP_ASHR, OP_SWAP, OP_SBSET, OP_SBCLR,
    OP_T_STORE, OP_T_LOAD, OP_MOVE, OP_PAIR_COPY, OP_IMM,
    OP_IND_LOAD, OP_IND_STORE, OP_DIR_LOAD, OP_DIR_STORE,
    OP_PM_LOAD, OP_PM_STORE, OP_PORT_IN, OP_PORT_OUT,
    OP_PUSH, OP_POP, OP_SLEEP, OP_WD_RESTART, OP_BREAK
  } cbe_op_type;

  // pointer addressing modes
  typedef enum logic [1:0] {
    AM_PLAIN, AM_POST_INC, AM_PRE_DEC, AM_DISP
  } cbe_mode_type;

  // core sequencer states
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_DM   = 5'h02,
    S_PM1  = 5'h04,
    S_PM2  = 5'h08,
    S_PMWR = 5'h10
  } cbe_state_type;

endpackage

// File: pkg/cbe_exec_if.sv
// Purpose: carrier between the core and its bit and address units
// Assumes: purely combinational units
// Notes:   core drives operands, units answer in the same cycle
`timescale 1ns/1ps
interface cbe_exec_if;
  import cbe_pkg::*;
  cbe_op_type   op;
  logic [7:0]   opnd;
  logic [2:0]   bit_sel;
  logic [7:0]   stat_in;
  logic [7:0]   res;
  logic [7:0]   stat_out;
  logic [15:0]  ptr;
  cbe_mode_type mode;
  logic [5:0]   disp;
  logic [15:0]  ea;
  logic [15:0]  ptr_next;

  modport core  (output op, opnd, bit_sel, stat_in, ptr, mode, disp,
                 input res, stat_out, ea, ptr_next);
  modport bitu  (input op, opnd, bit_sel, stat_in, output res, stat_out);
  modport addru (input ptr, mode, disp, output ea, ptr_next);
endinterface

// File: hdl/cbe_bit_unit.sv
// Purpose: shift, rotate, transfer-flag and status flag logic
// Assumes: operands stable within the cycle
// Notes:   result equals operand for ops that only touch flags
`timescale 1ns/1ps
module cbe_bit_unit
  import cbe_pkg::*;
(
  // link to the core
  cbe_exec_if.bitu bx
);

  // one shared flag path for both right shifts
  always_comb begin
    logic shift;
    shift = (bx.op == OP_ROT_RC) || (bx.op == OP_ASHR);
    bx.res = bx.opnd;
    bx.stat_out = bx.stat_in;
    case (bx.op)
      OP_ROT_RC:  bx.res = {bx.stat_in[FLAG_C], bx.opnd[7:1]};
      OP_ASHR:    bx.res = {bx.opnd[7], bx.opnd[7:1]};
      OP_SWAP:    bx.res = {bx.opnd[3:0], bx.opnd[7:4]};
      OP_SBSET:   bx.stat_out[bx.bit_sel] = 1'b1;
      OP_SBCLR:   bx.stat_out[bx.bit_sel] = 1'b0;
      OP_T_STORE: bx.stat_out[FLAG_T] = bx.opnd[bx.bit_sel];
      OP_T_LOAD:  bx.res[bx.bit_sel] = bx.stat_in[FLAG_T];
      default: begin
      end
    endcase
    if (shift) begin
      // carry takes the bit shifted out; v is n xor c by definition
      bx.stat_out[FLAG_C] = bx.opnd[0];
      bx.stat_out[FLAG_N] = bx.res[7];
      bx.stat_out[FLAG_Z] = (bx.res == 8'h00);
      bx.stat_out[FLAG_V] = bx.res[7] ^ bx.opnd[0];
      bx.stat_out[FLAG_S] = bx.opnd[0];
    end
  end

endmodule // cbe_bit_unit

// File: hdl/cbe_addr_unit.sv
// Purpose: effective address and pointer update for pointer accesses
// Assumes: displacement is six bits, unsigned
// Notes:   pointer wraps at 16 bits
`timescale 1ns/1ps
module cbe_addr_unit
  import cbe_pkg::*;
(
  // link to the core
  cbe_exec_if.addru ax
);

  // address used and pointer written back, per mode
  always_comb begin
    ax.ea = ax.ptr;
    ax.ptr_next = ax.ptr;
    case (ax.mode)
      AM_POST_INC: ax.ptr_next = ax.ptr + 16'h0001;
      AM_PRE_DEC: begin
        ax.ptr_next = ax.ptr - 16'h0001;
        ax.ea = ax.ptr - 16'h0001;
      end
      AM_DISP: ax.ea = ax.ptr + {10'h000, ax.disp};
      default: begin
      end
    endcase
  end

endmodule // cbe_addr_unit

// File: hdl/cbe_exec_core.sv
// Purpose: executes decoded bit-op, transfer and control instructions
// Assumes: data memory read is combinational on dm_addr_q; program memory
//          answers one cycle after pm_re_q
// Notes:   ins_ready_q low while a multi-cycle instruction is in flight
`timescale 1ns/1ps

module cbe_exec_core
  import cbe_pkg::*;
#(
  parameter logic [15:0] SP_INIT = SP_RESET
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // decoded instruction
  input  wire logic         ins_valid,
  input  wire cbe_op_type   ins_op,
  input  wire logic [4:0]   ins_rd,
  input  wire logic [4:0]   ins_rr,
  input  wire logic [2:0]   ins_bit,
  input  wire logic [1:0]   ins_ptr,
  input  wire cbe_mode_type ins_mode,
  input  wire logic [15:0]  ins_imm,
  output logic              ins_ready_q,
  // data memory
  output logic [15:0]       dm_addr_q,
  output logic [7:0]        dm_wdata_q,
  output logic              dm_we_q,
  output logic              dm_re_q,
  input  wire logic [7:0]   dm_rdata,
  // program memory
  output logic [15:0]       pm_addr_q,
  output logic              pm_re_q,
  input  wire logic [7:0]   pm_rdata,
  output logic              pm_we_q,
  output logic [15:0]       pm_wdata_q,
  input  wire logic         pm_done,
  // port space
  input  wire logic [7:0]   io_rdata,
  output logic [5:0]        io_addr_q,
  output logic [7:0]        io_wdata_q,
  output logic              io_we_q,
  output logic              io_re_q,
  // system control
  output logic              sleep_req_q,
  output logic              watchdog_restart_q,
  output logic              brk_req_q,
  // observation
  input  wire logic [4:0]   view_sel,
  output logic [7:0]        reg_view_q,
  output logic [7:0]        status_register_q,
  output logic [15:0]       stack_ptr_q
);

  typedef struct packed {
    cbe_state_type    state;
    logic [31:0][7:0] regs;
    logic [7:0]       stat;
    logic [15:0]      sp;
    logic [4:0]       dst;
    logic             is_load;
    logic             ready;
    logic [15:0]      dm_addr;
    logic [7:0]       dm_wdata;
    logic             dm_we;
    logic             dm_re;
    logic [15:0]      pm_addr;
    logic             pm_re;
    logic             pm_we;
    logic [15:0]      pm_wdata;
    logic [5:0]       io_addr;
    logic [7:0]       io_wdata;
    logic             io_we;
    logic             io_re;
    logic             sleep_req;
    logic             watchdog_restart;
    logic             brk_req;
    logic [7:0]       reg_view;
  } cbe_core_type;

  localparam cbe_core_type CORE_RESET = '{state: S_IDLE, stat: STATUS_RESET, sp: SP_INIT,
                                          ready: 1'b1, default: '0};

  cbe_core_type cur;
  cbe_core_type nxt;
  cbe_exec_if   ex ();
  logic [4:0]   pb;
  logic         accept;

  cbe_bit_unit u_bit (
    .bx (ex)
  );

  cbe_addr_unit u_addr (
    .ax (ex)
  );

  // program memory ops always go through the z pair
  assign pb = (ins_op == OP_PM_LOAD) ? PTR_Z_LO : PTR_X_LO + {2'b00, ins_ptr, 1'b0};
  assign accept = ins_valid && cur.ready && (cur.state == S_IDLE);

  // operands for the helper units
  always_comb begin
    ex.op = ins_op;
    ex.opnd = cur.regs[ins_rd];
    ex.bit_sel = ins_bit;
    ex.stat_in = cur.stat;
    ex.ptr = {cur.regs[pb + 5'd1], cur.regs[pb]};
    ex.mode = ins_mode;
    ex.disp = ins_imm[5:0];
  end

  // sequencer and register file next state
  always_comb begin
    nxt = cur;
    nxt.dm_we = 1'b0;
    nxt.dm_re = 1'b0;
    nxt.pm_re = 1'b0;
    nxt.io_we = 1'b0;
    nxt.io_re = 1'b0;
    nxt.sleep_req = 1'b0;
    nxt.watchdog_restart = 1'b0;
    nxt.brk_req = 1'b0;
    nxt.reg_view = cur.regs[view_sel];
    case (cur.state)
      S_IDLE: begin
        if (accept) begin
          case (ins_op)
            OP_ROT_RC, OP_ASHR, OP_SWAP, OP_SBSET, OP_SBCLR, OP_T_STORE, OP_T_LOAD: begin
              nxt.regs[ins_rd] = ex.res;
              nxt.stat = ex.stat_out;
            end
            OP_MOVE: nxt.regs[ins_rd] = cur.regs[ins_rr];
            OP_PAIR_COPY: begin
              nxt.regs[{ins_rd[4:1], 1'b0}] = cur.regs[{ins_rr[4:1], 1'b0}];
              nxt.regs[{ins_rd[4:1], 1'b1}] = cur.regs[{ins_rr[4:1], 1'b1}];
            end
            OP_IMM: nxt.regs[ins_rd] = ins_imm[7:0];
            OP_PORT_IN: begin
              // the port space decodes ins_imm itself so the read fits one cycle
              nxt.regs[ins_rd] = io_rdata;
              nxt.io_addr = ins_imm[5:0];
              nxt.io_re = 1'b1;
            end
            OP_PORT_OUT: begin
              nxt.io_addr = ins_imm[5:0];
              nxt.io_wdata = cur.regs[ins_rr];
              nxt.io_we = 1'b1;
            end
            OP_IND_LOAD, OP_IND_STORE: begin
              nxt.dm_addr = ex.ea;
              {nxt.regs[pb + 5'd1], nxt.regs[pb]} = ex.ptr_next;
              nxt.state = S_DM;
              nxt.ready = 1'b0;
            end
            OP_DIR_LOAD, OP_DIR_STORE: begin
              nxt.dm_addr = ins_imm;
              nxt.state = S_DM;
              nxt.ready = 1'b0;
            end
            OP_PUSH: begin
              // stack grows down: write then decrement
              nxt.dm_addr = cur.sp;
              nxt.sp = cur.sp - 16'h0001;
              nxt.state = S_DM;
              nxt.ready = 1'b0;
            end
            OP_POP: begin
              nxt.dm_addr = cur.sp + 16'h0001;
              nxt.sp = cur.sp + 16'h0001;
              nxt.state = S_DM;
              nxt.ready = 1'b0;
            end
            OP_PM_LOAD: begin
              nxt.pm_addr = ex.ea;
              {nxt.regs[pb + 5'd1], nxt.regs[pb]} = ex.ptr_next;
              nxt.pm_re = 1'b1;
              nxt.dst = ins_rd;
              nxt.state = S_PM1;
              nxt.ready = 1'b0;
            end
            OP_PM_STORE: begin
              nxt.pm_addr = {cur.regs[PTR_Z_LO + 5'd1], cur.regs[PTR_Z_LO]};
              nxt.pm_wdata = {cur.regs[REG_ONE_IDX], cur.regs[REG_ZERO_IDX]};
              nxt.pm_we = 1'b1;
              nxt.state = S_PMWR;
              nxt.ready = 1'b0;
            end
            OP_SLEEP: nxt.sleep_req = 1'b1;
            OP_WD_RESTART: nxt.watchdog_restart = 1'b1;
            OP_BREAK: nxt.brk_req = 1'b1;
            default: begin
            end
          endcase
          // common data memory setup for the two-cycle transfers
          case (ins_op)
            OP_IND_LOAD, OP_DIR_LOAD, OP_POP: begin
              nxt.dm_re = 1'b1;
              nxt.is_load = 1'b1;
              nxt.dst = ins_rd;
            end
            OP_IND_STORE, OP_DIR_STORE, OP_PUSH: begin
              nxt.dm_we = 1'b1;
              nxt.is_load = 1'b0;
              nxt.dm_wdata = cur.regs[ins_rr];
            end
            default: begin
            end
          endcase
        end
      end
      S_DM: begin
        if (cur.is_load) begin
          nxt.regs[cur.dst] = dm_rdata;
        end
        nxt.state = S_IDLE;
        nxt.ready = 1'b1;
      end
      S_PM1: nxt.state = S_PM2;
      S_PM2: begin
        nxt.regs[cur.dst] = pm_rdata;
        nxt.state = S_IDLE;
        nxt.ready = 1'b1;
      end
      S_PMWR: begin
        // no fixed duration: hold the write until memory reports completion
        if (pm_done) begin
          nxt.pm_we = 1'b0;
          nxt.state = S_IDLE;
          nxt.ready = 1'b1;
        end
      end
      default: begin
        nxt.state = S_IDLE;
        nxt.ready = 1'b1;
      end
    endcase
  end

  // single state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cur <= CORE_RESET;
    end else begin
      cur <= nxt;
    end
  end

  assign ins_ready_q       = cur.ready;
  assign dm_addr_q         = cur.dm_addr;
  assign dm_wdata_q        = cur.dm_wdata;
  assign dm_we_q           = cur.dm_we;
  assign dm_re_q           = cur.dm_re;
  assign pm_addr_q         = cur.pm_addr;
  assign pm_re_q           = cur.pm_re;
  assign pm_we_q           = cur.pm_we;
  assign pm_wdata_q        = cur.pm_wdata;
  assign io_addr_q         = cur.io_addr;
  assign io_wdata_q        = cur.io_wdata;
  assign io_we_q           = cur.io_we;
  assign io_re_q           = cur.io_re;
  assign sleep_req_q       = cur.sleep_req;
  assign watchdog_restart_q = cur.watchdog_restart;
  assign brk_req_q         = cur.brk_req;
  assign reg_view_q        = cur.reg_view;
  assign status_register_q = cur.stat;
  assign stack_ptr_q       = cur.sp;

  // helper capture of the accepted instruction for the checks below
  logic         h_acc;
  cbe_op_type   h_op;
  cbe_mode_type h_mode;
  logic [4:0]   h_rd;
  logic [4:0]   h_pb;
  logic [2:0]   h_bit;
  logic [7:0]   h_val;
  logic [7:0]   h_stat;
  logic [15:0]  h_ptr;
  logic [15:0]  h_sp;
  logic [15:0]  ptr_now;

  always_ff @(posedge ref_clk) begin
    h_acc <= accept && !sys_rst;
    h_op <= ins_op;
    h_mode <= ins_mode;
    h_rd <= ins_rd;
    h_pb <= pb;
    h_bit <= ins_bit;
    h_val <= cur.regs[ins_rd];
    h_stat <= cur.stat;
    h_ptr <= ex.ptr;
    h_sp <= cur.sp;
  end

  assign ptr_now = {cur.regs[h_pb + 5'd1], cur.regs[h_pb]};

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_wait_one;
    !cur.ready ##1 cur.ready;
  endsequence

  property p_rot;
    h_acc && h_op == OP_ROT_RC |->
      cur.regs[h_rd] == {h_stat[FLAG_C], h_val[7:1]} && cur.stat[FLAG_C] == h_val[0];
  endproperty
  a_rot: assert property (p_rot) else $error("rotate result wrong");

  property p_ashr;
    h_acc && h_op == OP_ASHR |-> cur.regs[h_rd] == {h_val[7], h_val[7:1]} && cur.ready;
  endproperty
  a_ashr: assert property (p_ashr) else $error("shift result wrong");

  property p_tstore;
    h_acc && h_op == OP_T_STORE |->
      cur.stat[FLAG_T] == h_val[h_bit] && cur.stat[5:0] == h_stat[5:0] && cur.stat[7] == h_stat[7];
  endproperty
  a_tstore: assert property (p_tstore) else $error("transfer flag store wrong");

  property p_tload;
    h_acc && h_op == OP_T_LOAD |-> cur.regs[h_rd][h_bit] == h_stat[FLAG_T] && cur.stat == h_stat;
  endproperty
  a_tload: assert property (p_tload) else $error("transfer flag load wrong");

  property p_flag_set;
    h_acc && h_op == OP_SBSET |-> cur.stat == (h_stat | (8'h01 << h_bit));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag set wrong");

  property p_load_time;
    accept && (ins_op == OP_IND_LOAD || ins_op == OP_DIR_LOAD) |=> cur.dm_re ##0 s_wait_one;
  endproperty
  a_load_time: assert property (p_load_time) else $error("load not two cycles");

  property p_post_inc;
    h_acc && h_op == OP_IND_LOAD && h_mode == AM_POST_INC |->
      cur.dm_addr == h_ptr && ptr_now == h_ptr + 16'h0001;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post increment wrong");

  property p_pre_dec;
    h_acc && h_op == OP_IND_STORE && h_mode == AM_PRE_DEC |->
      cur.dm_we && cur.dm_addr == h_ptr - 16'h0001 && ptr_now == h_ptr - 16'h0001;
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("pre decrement wrong");

  property p_pm_time;
    accept && ins_op == OP_PM_LOAD |=> !cur.ready ##1 s_wait_one;
  endproperty
  a_pm_time: assert property (p_pm_time) else $error("program load not three cycles");

  property p_push;
    h_acc && h_op == OP_PUSH |->
      cur.dm_we && cur.dm_addr == h_sp && cur.sp == h_sp - 16'h0001 && cur.stat == h_stat;
  endproperty
  a_push: assert property (p_push) else $error("push wrong");

  property p_pm_store_hold;
    cur.state == S_PMWR && !pm_done |=> cur.pm_we && !cur.ready;
  endproperty
  a_pm_store_hold: assert property (p_pm_store_hold) else $error("program store released early");

  property p_sleep;
    accept && ins_op == OP_SLEEP |=> cur.sleep_req && cur.ready && $stable(cur.stat) ##1 !cur.sleep_req;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep request wrong");

endmodule // cbe_exec_core

// File: verification/cbe_mem_model.sv
// Purpose: data and program memory facing the execution core
// Assumes: addresses stay below 256, one clock domain
// Notes:   unstrobed outputs show inverted data so a stale value never matches
`timescale 1ns/1ps
module cbe_mem_model (
  // clock and store latency
  input  wire logic        ref_clk,
  input  wire logic [3:0]  pm_wait,
  // data memory
  input  wire logic [15:0] dm_addr,
  input  wire logic [7:0]  dm_wdata,
  input  wire logic        dm_we,
  input  wire logic        dm_re,
  output logic [7:0]       dm_rdata,
  // program memory
  input  wire logic [15:0] pm_addr,
  input  wire logic        pm_re,
  input  wire logic        pm_we,
  output logic [7:0]       pm_rdata,
  output logic             pm_done
);
  logic [7:0] mem [256];
  logic [3:0] cnt;

  // preset pattern, mirrored by the bench
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
    pm_rdata = 8'h00;
    pm_done = 1'b0;
    cnt = 4'h0;
  end

  // combinational read only while strobed
  assign dm_rdata = dm_re ? mem[dm_addr[7:0]] : ~mem[dm_addr[7:0]];

  // program data one cycle late; store done pm_wait+1 cycles after the write strobe rises (slow or prompt)
  always @(posedge ref_clk) begin
    if (dm_we) mem[dm_addr[7:0]] <= dm_wdata;
    pm_rdata <= pm_re ? pm_addr[7:0] ^ 8'ha5 : ~pm_rdata;
    cnt <= pm_we ? cnt + 4'h1 : 4'h0;
    pm_done <= pm_we && cnt == pm_wait;
  end
endmodule // cbe_mem_model

// File: verification/cpu_bitops_transfer_exec_tb_top.sv
// Purpose: self-checking bench of the execution core against a reference model
// Assumes: pointers and stack stay below address 256
// Notes:   offers stay up while busy, so a stored refusal would run twice
`timescale 1ns/1ps
module cpu_bitops_transfer_exec_tb_top;
  import cbe_pkg::*;
  logic        ref_clk, sys_rst, ins_valid, ins_ready_q, dm_we_q, dm_re_q, pm_re_q, pm_we_q, pm_done;
  logic        io_we_q, io_re_q, sleep_req_q, watchdog_restart_q, brk_req_q;
  cbe_op_type  ins_op;
  cbe_mode_type ins_mode;
  logic [4:0]  ins_rd, ins_rr, view_sel;
  logic [2:0]  ins_bit;
  logic [1:0]  ins_ptr;
  logic [5:0]  io_addr_q;
  logic [3:0]  pm_wait;
  logic [7:0]  dm_wdata_q, dm_rdata, pm_rdata, io_rdata, io_wdata_q, reg_view_q, status_register_q, s;
  logic [15:0] ins_imm, dm_addr_q, pm_addr_q, pm_wdata_q, stack_ptr_q, sp;
  logic [7:0]  r [32];
  logic [7:0]  m [256];
  int          failures, num_checks, seed;

  cbe_exec_core i_dut (.ref_clk, .sys_rst, .ins_valid, .ins_op, .ins_rd, .ins_rr, .ins_bit, .ins_ptr,
    .ins_mode, .ins_imm, .ins_ready_q, .dm_addr_q, .dm_wdata_q, .dm_we_q, .dm_re_q, .dm_rdata, .pm_addr_q,
    .pm_re_q, .pm_rdata, .pm_we_q, .pm_wdata_q, .pm_done, .io_rdata, .io_addr_q, .io_wdata_q, .io_we_q,
    .io_re_q, .sleep_req_q, .watchdog_restart_q, .brk_req_q, .view_sel, .reg_view_q, .status_register_q,
    .stack_ptr_q);
  cbe_mem_model i_mem (.ref_clk, .pm_wait, .dm_addr(dm_addr_q), .dm_wdata(dm_wdata_q), .dm_we(dm_we_q),
    .dm_re(dm_re_q), .dm_rdata, .pm_addr(pm_addr_q), .pm_re(pm_re_q), .pm_we(pm_we_q), .pm_rdata, .pm_done);

  // free-running clock, 50 ns period
  always #25 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] g, x);
    num_checks++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one instruction: offer, model step, strobes, busy length, results
  task automatic ex(input cbe_op_type op, input logic [4:0] rd = 0, rr = 0, input logic [2:0] b = 0,
                    input logic [1:0] p = 0, input cbe_mode_type md = AM_PLAIN, input logic [15:0] k = 0);
    logic [7:0]  e, v, io;
    logic [15:0] a;
    int          n, c, pb;
    pb = 26 + 2 * p;
    io = 8'($random(seed));
    @(negedge ref_clk);
    ins_op = op;
    ins_rd = rd;
    ins_rr = rr;
    ins_bit = b;
    ins_ptr = p;
    ins_mode = md;
    ins_imm = k;
    io_rdata = io;
    ins_valid = 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    // strobe bits: sleep watchdog break io_we io_re dm_we dm_re pm_re
    e = 8'h00;
    c = 0;
    a = {r[pb + 1], r[pb]};
    case (op)
      OP_IMM: r[rd] = k[7:0];
      OP_MOVE: r[rd] = r[rr];
      OP_PAIR_COPY: {r[{rd[4:1], 1'b1}], r[{rd[4:1], 1'b0}]} = {r[{rr[4:1], 1'b1}], r[{rr[4:1], 1'b0}]};
      OP_ROT_RC, OP_ASHR: begin
        v = {op == OP_ROT_RC ? s[0] : r[rd][7], r[rd][7:1]};
        s[0] = r[rd][0];
        r[rd] = v;
        s[3:1] = {v[7] ^ s[0], v[7], v == 8'h00};
        s[4] = s[2] ^ s[3];
      end
      OP_SBSET: s[b] = 1'b1;
      OP_SBCLR: s[b] = 1'b0;
      OP_T_STORE: s[6] = r[rd][b];
      OP_T_LOAD: r[rd][b] = s[6];
      OP_SWAP: r[rd] = {r[rd][3:0], r[rd][7:4]};
      OP_IND_LOAD, OP_IND_STORE: begin
        if (md == AM_PRE_DEC) a = a - 16'h1;
        if (md == AM_DISP) a = a + k[5:0];
        if (md == AM_PRE_DEC) {r[pb + 1], r[pb]} = a;
        if (md == AM_POST_INC) {r[pb + 1], r[pb]} = a + 16'h1;
        e = op == OP_IND_LOAD ? 8'h02 : 8'h04;
      end
      OP_DIR_LOAD, OP_DIR_STORE: begin
        a = k;
        e = op == OP_DIR_LOAD ? 8'h02 : 8'h04;
      end
      OP_PUSH: begin
        a = sp;
        sp = sp - 16'h1;
        e = 8'h04;
      end
      OP_POP: begin
        sp = sp + 16'h1;
        a = sp;
        e = 8'h02;
      end
      OP_PM_LOAD, OP_PM_STORE: begin
        a = {r[31], r[30]};
        if (op == OP_PM_LOAD && md == AM_POST_INC) {r[31], r[30]} = a + 16'h1;
        e = op == OP_PM_LOAD ? 8'h01 : 8'h00;
        c = op == OP_PM_LOAD ? 2 : 2 + pm_wait;
      end
      OP_PORT_IN: begin
        r[rd] = io;
        e = 8'h08;
      end
      OP_PORT_OUT: e = 8'h10;
      OP_SLEEP: e = 8'h80;
      OP_WD_RESTART: e = 8'h40;
      OP_BREAK: e = 8'h20;
      default: ;
    endcase
    if (|e[2:1]) c = 1;
    chk({sleep_req_q, watchdog_restart_q, brk_req_q, io_we_q, io_re_q, dm_we_q, dm_re_q, pm_re_q}, e);
    if (|e[2:1]) chk(dm_addr_q, a);
    if (e[2]) chk(dm_wdata_q, r[rr]);
    if (op inside {OP_PM_LOAD, OP_PM_STORE}) chk(pm_addr_q, a);
    if (op == OP_PM_STORE) chk({pm_we_q, pm_wdata_q}, {1'b1, r[1], r[0]});
    if (e[4]) chk({io_addr_q, io_wdata_q}, {k[5:0], r[rr]});
    if (e[3]) chk(io_addr_q, k[5:0]);
    if (e[1]) r[rd] = m[a[7:0]];
    if (e[2]) m[a[7:0]] = r[rr];
    if (e[0]) r[rd] = a[7:0] ^ 8'ha5;
    n = 0;
    while (ins_ready_q !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    ins_valid = 1'b0;
    view_sel = rd;
    chk(n, c);
    @(negedge ref_clk);
    chk(reg_view_q, r[rd]);
    chk(status_register_q, s);
    chk(stack_ptr_q, sp);
  endtask

  // every register through the observation port
  task automatic cmp_all();
    for (int i = 0; i < 32; i++) begin
      view_sel = 5'(i);
      @(negedge ref_clk);
      chk(reg_view_q, r[i]);
    end
  endtask

  // hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    test_done();
  end

  initial begin
    {ref_clk, sys_rst, ins_valid, view_sel, io_rdata, pm_wait} = {1'b0, 1'b1, 1'b0, 5'h00, 8'h00, 4'h0};
    {ins_rd, ins_rr, ins_bit, ins_ptr, ins_imm} = '0;
    ins_op = OP_NOP;
    ins_mode = AM_PLAIN;
    seed = 32'h2646;
    for (int i = 0; i < 256; i++) m[i] = 8'(i) ^ 8'h3c;
    for (int i = 0; i < 32; i++) r[i] = 8'h00;
    s = STATUS_RESET;
    sp = SP_RESET;
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk({ins_ready_q, status_register_q, stack_ptr_q}, {1'b1, STATUS_RESET, SP_RESET});
    cmp_all();
    // random operands, pointers at 0x68, 0x70, 0x78
    for (int i = 0; i < 32; i++) ex(OP_IMM, 5'(i), 0, 0, 0, AM_PLAIN, {8'h00, i > 25 ? 8'(i[0] ? 0 : i * 4) : 8'($random(seed))});
    // each flag set and cleared around shifts and transfer-flag moves
    for (int i = 0; i < 8; i++) begin
      ex(OP_SBSET, 0, 0, 3'(i));
      ex(OP_ROT_RC, 5'(16 + i));
      ex(OP_SBCLR, 0, 0, 3'(i));
      ex(OP_ASHR, 5'(17 + i));
      ex(OP_T_STORE, 5'(16 + i), 0, 3'(i));
      ex(OP_T_LOAD, 5'(21), 0, 3'(7 - i));
    end
    ex(OP_MOVE, 2, 16);
    ex(OP_PAIR_COPY, 4, 18);
    // nibble swap and an idle slot must leave the flags alone
    ex(OP_SWAP, 5'd20);
    ex(OP_NOP, 5'd20);
    // every pointer and addressing mode except displacement on the x pair, store then load
    for (int p = 0; p < 3; p++) begin
      for (int md = 0; md < 4; md++) begin
        if (!(md == 3 && p == 0)) begin
          ex(OP_IND_STORE, 0, 5'(8 + md), 0, 2'(p), cbe_mode_type'(md), 16'($random(seed)) & 16'h003f);
          ex(OP_IND_LOAD, 5'(12 + md), 0, 0, 2'(p), cbe_mode_type'(md), 16'($random(seed)) & 16'h003f);
        end
      end
    end
    ex(OP_DIR_STORE, 0, 9, 0, 0, AM_PLAIN, 16'h0033);
    ex(OP_DIR_LOAD, 3, 0, 0, 0, AM_PLAIN, 16'h0033);
    ex(OP_PUSH, 0, 16);
    ex(OP_PUSH, 0, 17);
    ex(OP_POP, 6);
    ex(OP_POP, 7);
    ex(OP_PM_LOAD);
    ex(OP_PM_LOAD, 7, 0, 0, 0, AM_POST_INC);
    ex(OP_PM_LOAD, 8, 0, 0, 0, AM_POST_INC);
    // prompt and slow program store completion
    ex(OP_PM_STORE);
    pm_wait = 4'h5;
    ex(OP_PM_STORE);
    ex(OP_PORT_IN, 10, 0, 0, 0, AM_PLAIN, 16'h0015);
    ex(OP_PORT_OUT, 0, 9, 0, 0, AM_PLAIN, 16'h002a);
    ex(OP_SLEEP);
    ex(OP_WD_RESTART);
    ex(OP_BREAK);
    cmp_all();
    test_done();
  end
endmodule // cpu_bitops_transfer_exec_tb_top
